// >>> logic/dio_port_defines.vh
// Constants of the onboard digital I/O port: offsets, fields, resets, timings.
// Assumes a 50 MHz clock and a 32-bit classic Wishbone register bus.
`ifndef DIO_PORT_DEFINES_VH
`define DIO_PORT_DEFINES_VH

// Register indices; the byte address is four times the index
`define IDX_IMAGE_LOW      8'h88
`define IDX_IMAGE_HIGH     8'h89
`define IDX_RISE_EN        8'h90
`define IDX_FALL_EN        8'h91
`define IDX_DELAY_SEL      8'h92
`define IDX_IRQ_STATUS     8'h93
`define IDX_IRQ_MASK       8'h94
`define IDX_EDGE_PEND      8'h95
`define IDX_FUNC_SEL       8'h96
`define IDX_LAMP_STATUS    8'h97

// Status and mask bits
`define IRQ_BIT_HW         0
`define IRQ_BIT_DIAG       1

// Delay selection codes
`define DLY_0P1            2'h0
`define DLY_0P5            2'h1
`define DLY_3              2'h2
`define DLY_15             2'h3

// Delay times in microseconds and clock rate in MHz
`define CLK_MHZ            50
`define T_0P1_US           100
`define T_0P5_US           500
`define T_3_US             3000
`define T_15_US            15000
`define CYC_0P1            (`T_0P1_US * `CLK_MHZ)
`define CYC_0P5            (`T_0P5_US * `CLK_MHZ)
`define CYC_3              (`T_3_US * `CLK_MHZ)
`define CYC_15             (`T_15_US * `CLK_MHZ)

// Inputs wired to counter, frequency, gate and latch functions
`define FAST_MASK          16'h8EDB

// Reset values
`define RST_OUT            8'h00
`define RST_EN             16'h0000
`define RST_DELAY          8'hAA
`define RST_MASK           2'h0

`endif

// >>> logic/dio_port.v
// Onboard 16-input / 12-output digital I/O port with filter, edge interrupts and lamps.
// Assumes synchronous field inputs and a classic Wishbone master on the register side.
`timescale 1ns/1ps
`include "dio_port_defines.vh"

module dio_port #(
    parameter integer N_IN      = 16,
    parameter integer CNT_W     = 20,
    parameter integer CYC_0P1_P = `CYC_0P1,
    parameter integer CYC_0P5_P = `CYC_0P5,
    parameter integer CYC_3_P   = `CYC_3,
    parameter integer CYC_15_P  = `CYC_15
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [9:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output reg         err_o,
    input  wire [15:0] field_input_i,
    input  wire [11:0] out_fault_i,
    input  wire        electronics_supply_i,
    input  wire        input_power_supply_i,
    input  wire        output_power_supply_i,
    input  wire [3:0]  counter_out_i,
    input  wire [1:0]  pwm_out_i,
    output reg  [11:0] field_output_o,
    output reg  [15:0] input_lamp_o,
    output reg         fault_lamp_o,
    output reg         electronics_lamp_o,
    output reg         input_power_lamp_o,
    output reg         output_power_lamp_o,
    output wire        irq_o,
    output reg         diag_irq_o,
    output reg  [15:0] edge_event_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    reg  [7:0]  out_low_r;
    reg  [3:0]  out_high_r;
    reg  [15:0] rise_en_r;
    reg  [15:0] fall_en_r;
    reg  [7:0]  delay_sel_r;
    reg  [1:0]  irq_status_r;
    reg  [1:0]  irq_mask_r;
    reg  [15:0] pend_r;
    reg  [5:0]  func_sel_r;
    wire [15:0] filt_r;
    reg  [15:0] filt_d_r;

    wire        bus_req;
    wire        wr_req;
    wire [7:0]  reg_idx;
    wire [15:0] fast_mask;
    wire [15:0] edge_hit;
    wire [15:0] lost_hit;
    wire [15:0] pend_clr;
    wire [1:0]  status_clr;
    reg         hit_known;
    reg  [31:0] rd_nxt;

    assign bus_req   = cyc_i & stb_i & ~ack_o & ~err_o;
    assign wr_req    = bus_req & we_i & sel_i[0];
    assign reg_idx   = adr_i[9:2];
    assign fast_mask = `FAST_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // Input delay filter, one counter per input

    genvar g;
    generate
        for (g = 0; g < N_IN; g = g + 1) begin : flt
            reg  [CNT_W-1:0] cnt_r;
            reg  [1:0]       code;
            reg  [CNT_W-1:0] limit;
            reg              bit_r;
            assign filt_r[g] = bit_r;
            always @* begin
                code = delay_sel_r[2*(g/4) +: 2];
                if (code == `DLY_0P1 && !fast_mask[g]) begin
                    code = `DLY_0P5;
                end
                case (code)
                    `DLY_0P1: limit = CYC_0P1_P[CNT_W-1:0];
                    `DLY_0P5: limit = CYC_0P5_P[CNT_W-1:0];
                    `DLY_3:   limit = CYC_3_P[CNT_W-1:0];
                    default:  limit = CYC_15_P[CNT_W-1:0];
                endcase
            end
            always @(posedge clk_i) begin
                if (rst_i) begin
                    cnt_r <= {CNT_W{1'b0}};
                    bit_r <= 1'b0;
                end else if (field_input_i[g] == bit_r) begin
                    cnt_r <= {CNT_W{1'b0}};
                end else if (cnt_r >= limit - 1'b1) begin
                    cnt_r <= {CNT_W{1'b0}};
                    bit_r <= field_input_i[g];
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection and interrupt pending

    assign edge_hit = (rise_en_r & filt_r & ~filt_d_r)
                    | (fall_en_r & ~filt_r & filt_d_r);
    assign lost_hit = edge_hit & pend_r;
    assign pend_clr = (wr_req && reg_idx == `IDX_EDGE_PEND) ? dat_i[15:0] : 16'h0000;
    assign status_clr = (wr_req && reg_idx == `IDX_IRQ_STATUS) ? dat_i[1:0] : 2'h0;

    always @(posedge clk_i) begin
        if (rst_i) begin
            filt_d_r     <= 16'h0000;
            pend_r       <= 16'h0000;
            irq_status_r <= 2'h0;
            edge_event_o <= 16'h0000;
            diag_irq_o   <= 1'b0;
        end else begin
            filt_d_r     <= filt_r;
            pend_r       <= (pend_r & ~pend_clr) | edge_hit;
            edge_event_o <= edge_hit;
            diag_irq_o   <= |lost_hit;
            irq_status_r[`IRQ_BIT_HW]   <= (irq_status_r[`IRQ_BIT_HW] & ~status_clr[`IRQ_BIT_HW])
                                         | (|edge_hit);
            irq_status_r[`IRQ_BIT_DIAG] <= (irq_status_r[`IRQ_BIT_DIAG] & ~status_clr[`IRQ_BIT_DIAG])
                                         | (|lost_hit);
        end
    end

    assign irq_o = |(irq_status_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    always @(posedge clk_i) begin
        if (rst_i) begin
            out_low_r   <= `RST_OUT;
            out_high_r  <= 4'h0;
            rise_en_r   <= `RST_EN;
            fall_en_r   <= `RST_EN;
            delay_sel_r <= `RST_DELAY;
            irq_mask_r  <= `RST_MASK;
            func_sel_r  <= 6'h00;
        end else if (wr_req) begin
            case (reg_idx)
                `IDX_IMAGE_LOW:  out_low_r   <= dat_i[7:0];
                `IDX_IMAGE_HIGH: out_high_r  <= dat_i[3:0];
                `IDX_RISE_EN:    rise_en_r   <= dat_i[15:0];
                `IDX_FALL_EN:    fall_en_r   <= dat_i[15:0];
                `IDX_DELAY_SEL:  delay_sel_r <= dat_i[7:0];
                `IDX_IRQ_MASK:   irq_mask_r  <= dat_i[1:0];
                `IDX_FUNC_SEL:   func_sel_r  <= dat_i[5:0];
                default:         func_sel_r  <= func_sel_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads and bus answer

    always @* begin
        hit_known = 1'b1;
        rd_nxt    = 32'h0000_0000;
        case (reg_idx)
            `IDX_IMAGE_LOW:   rd_nxt[7:0]  = filt_r[7:0];
            `IDX_IMAGE_HIGH:  rd_nxt[7:0]  = filt_r[15:8];
            `IDX_RISE_EN:     rd_nxt[15:0] = rise_en_r;
            `IDX_FALL_EN:     rd_nxt[15:0] = fall_en_r;
            `IDX_DELAY_SEL:   rd_nxt[7:0]  = delay_sel_r;
            `IDX_IRQ_STATUS:  rd_nxt[1:0]  = irq_status_r;
            `IDX_IRQ_MASK:    rd_nxt[1:0]  = irq_mask_r;
            `IDX_EDGE_PEND:   rd_nxt[15:0] = pend_r;
            `IDX_FUNC_SEL:    rd_nxt[5:0]  = func_sel_r;
            `IDX_LAMP_STATUS: rd_nxt[15:0] = {out_high_r, out_low_r, fault_lamp_o, electronics_lamp_o,
                                              input_power_lamp_o, output_power_lamp_o};
            default:          hit_known    = 1'b0;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req & hit_known;
            err_o <= bus_req & ~hit_known;
            dat_o <= (bus_req & ~we_i & hit_known) ? rd_nxt : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, shared functions and lamps

    always @(posedge clk_i) begin
        if (rst_i) begin
            field_output_o      <= 12'h000;
            input_lamp_o        <= 16'h0000;
            fault_lamp_o        <= 1'b0;
            electronics_lamp_o  <= 1'b0;
            input_power_lamp_o  <= 1'b0;
            output_power_lamp_o <= 1'b0;
        end else begin
            field_output_o[11:4] <= {out_high_r, out_low_r[7:4]};
            field_output_o[3:2]  <= {func_sel_r[3] ? counter_out_i[3] : out_low_r[3],
                                     func_sel_r[2] ? counter_out_i[2] : out_low_r[2]};
            field_output_o[1]    <= func_sel_r[5] ? pwm_out_i[1] :
                                    (func_sel_r[1] ? counter_out_i[1] : out_low_r[1]);
            field_output_o[0]    <= func_sel_r[4] ? pwm_out_i[0] :
                                    (func_sel_r[0] ? counter_out_i[0] : out_low_r[0]);
            input_lamp_o         <= filt_r;
            fault_lamp_o         <= |out_fault_i;
            electronics_lamp_o   <= electronics_supply_i;
            input_power_lamp_o   <= input_power_supply_i;
            output_power_lamp_o  <= output_power_supply_i;
        end
    end

endmodule

// >>> verif/dio_port_monitor.sv
// Checker of the I/O port: bus answers, lamps, filter and edge events.
// Assumes binding onto dio_port, one clock and a synchronous reset.
`timescale 1ns/1ps
module dio_port_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [9:0]  adr_i,
    input wire logic        ack_o,
    input wire logic        err_o,
    input wire logic [15:0] field_input_i,
    input wire logic [11:0] out_fault_i,
    input wire logic [15:0] input_lamp_o,
    input wire logic        fault_lamp_o,
    input wire logic        diag_irq_o,
    input wire logic [15:0] edge_event_o
);
logic [2:0] quiet_r;
always_ff @(posedge clk_i) quiet_r <= rst_i ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
////////////////////////////////////////
bus_answer_a: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o)
    else $error("request not answered");
ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
err_pulse_a: assert property (err_o |=> !err_o) else $error("err too long");
bad_index_a: assert property (cyc_i && stb_i && !ack_o && !err_o && (adr_i[9:2] < 8'h88 || adr_i[9:2] > 8'h97)
    |=> err_o && !ack_o) else $error("unmapped index accepted");
fault_lamp_a: assert property (
    quiet_r != 3'h0 |-> fault_lamp_o == $past(|out_fault_i)) else $error("fault lamp wrong");
filter_hold_a: assert property (
    quiet_r == 3'h7 |-> ((input_lamp_o ^ $past(input_lamp_o)) & (($past(field_input_i, 3) ^ input_lamp_o)
    | ($past(field_input_i, 4) ^ input_lamp_o))) == 16'h0) else $error("lamp changed before filter time");
event_cause_a: assert property (
    quiet_r == 3'h7 |-> (edge_event_o & ~((input_lamp_o ^ $past(input_lamp_o)) | ($past(input_lamp_o)
    ^ $past(input_lamp_o, 2)) | ($past(input_lamp_o, 2) ^ $past(input_lamp_o, 3)))) == 16'h0)
    else $error("edge event without filtered change");
diag_cause_a: assert property (
    diag_irq_o |-> (edge_event_o | $past(edge_event_o)) != 16'h0) else $error("diag without edge");
////////////////////////////////////////
cover property (|edge_event_o);
cover property (diag_irq_o);
cover property (err_o);
endmodule
bind dio_port dio_port_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i),
    .ack_o(ack_o), .err_o(err_o), .field_input_i(field_input_i), .out_fault_i(out_fault_i),
    .input_lamp_o(input_lamp_o), .fault_lamp_o(fault_lamp_o), .diag_irq_o(diag_irq_o), .edge_event_o(edge_event_o));

// >>> verif/field_model.sv
// Field side: sensors, supplies and shorted loads on the outputs.
// Assumes the bench sets sensor, load and supply states.
`timescale 1ns/1ps
module field_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] sense_i,
    input  wire logic [11:0] load_i,
    input  wire logic [2:0]  supply_i,
    input  wire logic [11:0] field_output_i,
    output logic      [15:0] field_input_o = 16'h0,
    output logic      [11:0] out_fault_o = 12'h0,
    output logic      [2:0]  supply_o = 3'h0
);
always @(posedge clk_i) begin
    field_input_o <= sense_i;
    out_fault_o   <= load_i & field_output_i;
    supply_o      <= supply_i;
end
endmodule

// >>> verif/tb_onboard_digital_io_port.sv
// Bench of the I/O port: registers, outputs, lamps, filter, interrupts.
// Assumes the port, its checker and the field model.
`timescale 1ns/1ps
`include "dio_port_defines.vh"
module tb_onboard_digital_io_port;
localparam logic [15:0] FAST = `FAST_MASK;
logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, irq_o, diag_irq_o, fault_lamp_o, clr, dg, be;
logic        electronics_supply_i, input_power_supply_i, output_power_supply_i;
logic        electronics_lamp_o, input_power_lamp_o, output_power_lamp_o;
logic [9:0]  adr_i;
logic [3:0]  sel_i, counter_out_i;
logic [1:0]  pwm_out_i;
logic [31:0] dat_i, dat_o, rd, d;
logic [15:0] field_input_i, input_lamp_o, edge_event_o, sense, ed, ex, cr;
logic [11:0] out_fault_i, field_output_o, load;
logic [2:0]  supply;
integer      n_errors, n_checks, seed, i, k, b, l;
dio_port #(.CYC_0P1_P(4), .CYC_0P5_P(8), .CYC_3_P(16), .CYC_15_P(32)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .field_input_i(field_input_i),
    .out_fault_i(out_fault_i), .electronics_supply_i(electronics_supply_i),
    .input_power_supply_i(input_power_supply_i), .output_power_supply_i(output_power_supply_i),
    .counter_out_i(counter_out_i), .pwm_out_i(pwm_out_i), .field_output_o(field_output_o),
    .input_lamp_o(input_lamp_o), .fault_lamp_o(fault_lamp_o), .electronics_lamp_o(electronics_lamp_o),
    .input_power_lamp_o(input_power_lamp_o), .output_power_lamp_o(output_power_lamp_o), .irq_o(irq_o),
    .diag_irq_o(diag_irq_o), .edge_event_o(edge_event_o));
field_model u_field (.clk_i(clk_i), .sense_i(sense), .load_i(load), .supply_i(supply), .field_output_i(field_output_o),
    .field_input_o(field_input_i), .out_fault_o(out_fault_i),
    .supply_o({electronics_supply_i, input_power_supply_i, output_power_supply_i}));
always @(posedge clk_i) {ed, dg} <= clr ? 17'h0 : {ed | edge_event_o, dg | diag_irq_o};
initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
end
////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
        n_errors++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
task automatic wb(input logic w, input logic [7:0] x, input logic [31:0] v, input logic [3:0] s);
    integer t;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, x, 2'b00, v, s};
    t = 0;
    do begin
        @(posedge clk_i);
        t++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && t < 20);
    if (t >= 20) begin
        n_errors++;
        print_verdict;
    end
    {rd, be} = {dat_o, err_o};
    {cyc_i, stb_i} <= 2'b00;
endtask
// Flip the sensors and follow every lamp against its group delay
task automatic filt(input logic [15:0] nv, input logic [7:0] ds);
    logic [15:0] ov;
    ov = sense;
    wb(1'b1, `IDX_DELAY_SEL, {24'h0, ds}, 4'hF);
    sense <= nv;
    for (k = 1; k <= 40; k++) begin
        @(negedge clk_i);
        for (b = 0; b < 16; b++) begin
            l = 4 << ds[2 * (b / 4) +: 2];
            if (!FAST[b] && l < 8) l = 8;
            ex[b] = k <= l ? ov[b] : nv[b];
            cr[b] = k <= l || k >= l + 5;
        end
        chk("lamps", ex & cr, input_lamp_o & cr);
    end
    wb(1'b0, `IDX_IMAGE_LOW, 32'h0, 4'hF);
    chk("image low", nv[7:0], rd);
    wb(1'b0, `IDX_IMAGE_HIGH, 32'h0, 4'hF);
    chk("image high", nv[15:8], rd);
endtask
////////////////////////////////////////
initial begin
    seed = 32'h15112D5F;
    {n_errors, n_checks} = 64'h0;
    {rst_i, clr, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {2'b11, 49'h0};
    {counter_out_i, pwm_out_i, sense, load, supply} = 37'h0;
    repeat (10) @(posedge clk_i);
    {rst_i, clr} <= 2'b00;
    wb(1'b0, `IDX_RISE_EN, 32'h0, 4'hF);
    chk("rise enable", 32'h0, rd);
    wb(1'b0, 8'h98, 32'h0, 4'hF);
    chk("unmapped", 32'h1, be);
    for (i = 0; i < 4; i++) begin
        d = $random(seed);
        wb(1'b1, `IDX_IMAGE_LOW, d, 4'hF);
        wb(1'b1, `IDX_IMAGE_HIGH, d >> 8, 4'hF);
        wb(1'b1, `IDX_IMAGE_LOW, ~d, 4'hE);
        @(negedge clk_i);
        chk("outputs", d[11:0], field_output_o);
    end
    {counter_out_i, pwm_out_i} <= 6'($random(seed));
    wb(1'b1, `IDX_FUNC_SEL, 32'h3F, 4'hF);
    @(negedge clk_i);
    chk("shared outputs", {counter_out_i[3:2], pwm_out_i}, field_output_o[3:0]);
    wb(1'b1, `IDX_FUNC_SEL, 32'hF, 4'hF);
    @(negedge clk_i);
    chk("counter outputs", counter_out_i, field_output_o[3:0]);
    for (i = 0; i < 4; i++) begin
        @(posedge clk_i);
        {supply, load} <= i == 0 ? 15'h0 : 15'($random(seed));
        repeat (4) @(negedge clk_i);
        chk("supply lamps", supply, {electronics_lamp_o, input_power_lamp_o, output_power_lamp_o});
        chk("fault lamp", |(load & field_output_o), fault_lamp_o);
    end
    $display("outputs and lamps done");
    filt(16'hFFFF, 8'hE4);
    for (i = 0; i < 3; i++) filt(16'($random(seed)), 8'($random(seed)));
    filt(16'h0, 8'h00);
    chk("edges disabled", 32'h0, ed);
    $display("filter done");
    d = $random(seed) | 32'h10001;
    wb(1'b1, `IDX_RISE_EN, d[15:0], 4'hF);
    wb(1'b1, `IDX_FALL_EN, d[31:16], 4'hF);
    sense <= 16'hFFFF;
    repeat (3) @(posedge clk_i);
    sense <= 16'h0;
    repeat (20) @(posedge clk_i);
    chk("short pulse", 32'h0, ed);
    sense <= 16'hFFFF;
    repeat (20) @(posedge clk_i);
    chk("rising", d[15:0], ed);
    chk("no diag", 32'h0, dg);
    wb(1'b0, `IDX_IRQ_STATUS, 32'h0, 4'hF);
    chk("status", 32'h1, rd);
    wb(1'b0, `IDX_EDGE_PEND, 32'h0, 4'hF);
    chk("pending", d[15:0], rd);
    chk("irq masked", 32'h0, irq_o);
    clr <= 1'b1;
    @(posedge clk_i);
    {clr, sense} <= 17'h0;
    repeat (20) @(posedge clk_i);
    chk("falling", d[31:16], ed);
    chk("lost diag", 32'h1, dg);
    wb(1'b0, `IDX_IRQ_STATUS, 32'h0, 4'hF);
    chk("status lost", 32'h3, rd);
    wb(1'b1, `IDX_IRQ_MASK, 32'h3, 4'hF);
    chk("irq raised", 32'h1, irq_o);
    wb(1'b1, `IDX_IRQ_STATUS, 32'h3, 4'hF);
    chk("irq cleared", 32'h0, irq_o);
    $display("interrupts done");
    print_verdict;
end
endmodule
